// file: inc/sws_pkg.sv
// Constants, field layout and types of the standby wake-up source block.
`default_nettype none
package sws_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] SWS_CFG_A_ADDR = 32'hffff_ee10;
    localparam logic [31:0] SWS_IRQ_STAT_ADDR = 32'hffff_ee80;
    localparam logic [31:0] SWS_IRQ_MASK_ADDR = 32'hffff_ee84;
    localparam logic [31:0] SWS_LIVE_ADDR = 32'hffff_ee88;

    // ------------------------------------------------------------------
    // Field layout of one byte lane, source counts and live register bits
    // ------------------------------------------------------------------
    localparam int SWS_NUM_IN = 4;
    localparam int SWS_LANE_W = 8;
    localparam int SWS_EN_BIT = 0;
    localparam int SWS_ST_LO = 2;
    localparam int SWS_ST_HI = 3;
    localparam int SWS_CND_LO = 4;
    localparam int SWS_CND_HI = 6;
    localparam int SWS_NUM_OTHER = 8;
    localparam int SWS_NUM_KEY = 32;
    localparam int SWS_NUM_TPC = 2;
    localparam int SWS_LIVE_STOP = 4;
    localparam int SWS_LIVE_SLEEP = 5;
    localparam int SWS_LIVE_IDLE = 6;

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SWS_COND_LOW = 3'h0,
        SWS_COND_HIGH = 3'h1,
        SWS_COND_FALL = 3'h2,
        SWS_COND_RISE = 3'h3,
        SWS_COND_BOTH = 3'h4
    } sws_cond_t;

    localparam logic [1:0] SWS_ST_NONE = 2'h0;
    localparam logic [1:0] SWS_ST_RISE = 2'h1;
    localparam logic [1:0] SWS_ST_FALL = 2'h2;
    localparam logic [2:0] SWS_COND_RST = 3'h2;
    localparam logic SWS_EN_RST = 1'b0;
    localparam logic [3:0] SWS_IRQ_RST = 4'h0;
    localparam logic [31:0] SWS_ZERO32 = 32'h0000_0000;

endpackage
`default_nettype wire

// file: hdl/sws_detect.sv
// Synchroniser, condition match and edge status for one wake-up input.
`timescale 1ns/100ps
`default_nettype none
module sws_detect (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    input wire logic enable,
    input wire logic [2:0] cond,
    input wire logic clr_status,
    output logic request_q,
    output logic [1:0] status_q
);

    // ------------------------------------------------------------------
    // Synchroniser and edge detection
    // ------------------------------------------------------------------
    // The first stage feeds only the second; edges use stage two onward.
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic rise;
    logic fall;
    logic cond_hit;
    logic rise_rec;
    logic fall_rec;
    logic [1:0] status_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

    // ------------------------------------------------------------------
    // Condition match
    // ------------------------------------------------------------------
    always_comb begin
        case (sws_pkg::sws_cond_t'(cond))
            sws_pkg::SWS_COND_LOW: cond_hit = ~sync_q;
            sws_pkg::SWS_COND_HIGH: cond_hit = sync_q;
            sws_pkg::SWS_COND_FALL: cond_hit = fall;
            sws_pkg::SWS_COND_RISE: cond_hit = rise;
            sws_pkg::SWS_COND_BOTH: cond_hit = rise | fall;
            default: cond_hit = 1'b0;
        endcase
    end

    // Edges are recorded only for edge conditions that watch that edge.
    assign rise_rec = enable & rise &
        ((cond == sws_pkg::SWS_COND_RISE) | (cond == sws_pkg::SWS_COND_BOTH));
    assign fall_rec = enable & fall &
        ((cond == sws_pkg::SWS_COND_FALL) | (cond == sws_pkg::SWS_COND_BOTH));
    // A new edge in the clearing cycle survives the clear.
    assign status_d = (clr_status ? sws_pkg::SWS_ST_NONE : status_q) |
        (rise_rec ? sws_pkg::SWS_ST_RISE : sws_pkg::SWS_ST_NONE) |
        (fall_rec ? sws_pkg::SWS_ST_FALL : sws_pkg::SWS_ST_NONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_q <= 1'b0;
            status_q <= sws_pkg::SWS_ST_NONE;
        end else begin
            request_q <= enable & cond_hit;
            status_q <= status_d;
        end
    end

endmodule
`default_nettype wire

// file: hdl/sws_top.sv
// APB register block and standby release logic for wake-up inputs 0 to 3.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module sws_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] wake_pin,
    input wire logic [7:0] other_ext_release,
    input wire logic [31:0] key_wake_line,
    input wire logic rtc_event,
    input wire logic [1:0] two_phase_counter_event,
    output logic release_stop,
    output logic release_sleep,
    output logic release_idle,
    output logic [3:0] release_req,
    output logic irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Builds one read lane; bits 7 and 1 are never driven from state.
    function automatic logic [7:0] lane_pack(
        input logic en,
        input logic [2:0] cnd,
        input logic [1:0] st
    );
        logic [7:0] v;
        v = 8'h00;
        v[sws_pkg::SWS_EN_BIT] = en;
        v[sws_pkg::SWS_ST_HI:sws_pkg::SWS_ST_LO] = st;
        v[sws_pkg::SWS_CND_HI:sws_pkg::SWS_CND_LO] = cnd;
        return v;
    endfunction

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic pready_q;
    logic pready_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;
    logic access;
    logic done;
    logic wr_done;
    logic rd_cap;
    logic sel_cfg;
    logic sel_stat;
    logic sel_mask;
    logic sel_live;
    logic mapped;

    // One wait state lets read data leave a flip-flop.
    assign access = psel & penable;
    assign done = access & pready_q;
    assign wr_done = done & pwrite & mapped;
    // Read-clear acts on the edge that loads prdata, so an event that
    // lands on the completing edge is kept for the next read.
    assign rd_cap = pready_d & ~pwrite;
    assign sel_cfg = (paddr == sws_pkg::SWS_CFG_A_ADDR);
    assign sel_stat = (paddr == sws_pkg::SWS_IRQ_STAT_ADDR);
    assign sel_mask = (paddr == sws_pkg::SWS_IRQ_MASK_ADDR);
    assign sel_live = (paddr == sws_pkg::SWS_LIVE_ADDR);
    assign mapped = sel_cfg | sel_stat | sel_mask | sel_live;
    assign pready_d = access & ~pready_q;
    assign pslverr_d = access & ~pready_q & ~mapped;

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    logic [3:0] en_q;
    logic [3:0] en_d;
    logic [2:0] cond_q [sws_pkg::SWS_NUM_IN];
    logic [2:0] cond_d [sws_pkg::SWS_NUM_IN];
    logic [1:0] status [sws_pkg::SWS_NUM_IN];
    logic [3:0] req;
    logic [31:0] cfg_rd;
    logic clr_status;

    // Status is cleared on the edge that loads the read data.
    assign clr_status = rd_cap & sel_cfg;

    genvar gi;
    generate
        for (gi = 0; gi < sws_pkg::SWS_NUM_IN; gi++) begin : g_in
            localparam int B = gi * sws_pkg::SWS_LANE_W;
            logic lane_wr;
            assign lane_wr = wr_done & sel_cfg & pstrb[gi];
            assign en_d[gi] = lane_wr ?
                pwdata[B + sws_pkg::SWS_EN_BIT] : en_q[gi];
            assign cond_d[gi] = lane_wr ?
                pwdata[B + sws_pkg::SWS_CND_HI -: 3] : cond_q[gi];
            assign cfg_rd[B +: sws_pkg::SWS_LANE_W] =
                lane_pack(en_q[gi], cond_q[gi], status[gi]);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cond_q[gi] <= sws_pkg::SWS_COND_RST;
                end else begin
                    cond_q[gi] <= cond_d[gi];
                end
            end

            sws_detect u_detect (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(wake_pin[gi]),
                .enable(en_q[gi]),
                .cond(cond_q[gi]),
                .clr_status(clr_status),
                .request_q(req[gi]),
                .status_q(status[gi])
            );
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= {sws_pkg::SWS_NUM_IN{sws_pkg::SWS_EN_RST}};
        end else begin
            en_q <= en_d;
        end
    end

    // ------------------------------------------------------------------
    // Release outputs
    // ------------------------------------------------------------------
    // Neighbouring sources arrive already qualified on this clock.
    logic any_full;
    logic any_sleep_only;
    logic rel_stop_q;
    logic rel_sleep_q;
    logic rel_idle_q;
    logic [3:0] req_q;
    logic [3:0] req_prev_q;
    logic [3:0] req_event;

    assign any_full = (|req) | (|other_ext_release) | (|key_wake_line);
    assign any_sleep_only = rtc_event | (|two_phase_counter_event);
    assign req_event = req & ~req_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rel_stop_q <= 1'b0;
            rel_sleep_q <= 1'b0;
            rel_idle_q <= 1'b0;
            req_q <= 4'h0;
            req_prev_q <= 4'h0;
        end else begin
            rel_stop_q <= any_full;
            rel_sleep_q <= any_full | any_sleep_only;
            rel_idle_q <= any_full;
            req_q <= req;
            req_prev_q <= req;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    logic [3:0] irq_stat_q;
    logic [3:0] irq_stat_d;
    logic [3:0] irq_mask_q;
    logic [3:0] irq_mask_d;
    logic irq_q;

    // Set wins over the read-clear so no event is lost.
    assign irq_stat_d = ((rd_cap & sel_stat) ? sws_pkg::SWS_IRQ_RST :
        irq_stat_q) | req_event;
    assign irq_mask_d = (wr_done & sel_mask & pstrb[0]) ?
        pwdata[sws_pkg::SWS_NUM_IN-1:0] : irq_mask_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= sws_pkg::SWS_IRQ_RST;
            irq_mask_q <= sws_pkg::SWS_IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= |(irq_stat_d & irq_mask_d);
        end
    end

    // ------------------------------------------------------------------
    // Read mux and bus outputs
    // ------------------------------------------------------------------
    logic [31:0] stat_rd;
    logic [31:0] mask_rd;
    logic [31:0] live_rd;

    assign stat_rd = {28'h000_0000, irq_stat_q};
    assign mask_rd = {28'h000_0000, irq_mask_q};
    assign live_rd = {25'h000_0000, rel_idle_q, rel_sleep_q, rel_stop_q,
        req_q};
    assign prdata_d = (~pready_d | pwrite) ? sws_pkg::SWS_ZERO32 :
        sel_cfg ? cfg_rd :
        sel_stat ? stat_rd :
        sel_mask ? mask_rd :
        sel_live ? live_rd : sws_pkg::SWS_ZERO32;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= sws_pkg::SWS_ZERO32;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign release_stop = rel_stop_q;
    assign release_sleep = rel_sleep_q;
    assign release_idle = rel_idle_q;
    assign release_req = req_q;
    assign irq = irq_q;

endmodule
`default_nettype wire

// file: test/sws_monitor.sv
// Port assertions for the standby wake-up source block.
`timescale 1ns/100ps
`default_nettype none
module sws_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] other_ext_release,
    input wire logic [31:0] key_wake_line,
    input wire logic rtc_event,
    input wire logic [1:0] two_phase_counter_event,
    input wire logic release_stop,
    input wire logic release_sleep,
    input wire logic release_idle,
    input wire logic [3:0] release_req
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic is_cfg = paddr == sws_pkg::SWS_CFG_A_ADDR;
    wire logic mapped = is_cfg || paddr == sws_pkg::SWS_IRQ_STAT_ADDR
        || paddr == sws_pkg::SWS_IRQ_MASK_ADDR
        || paddr == sws_pkg::SWS_LIVE_ADDR;
    // Wake-input requests show on release_req and on the release outputs
    // at the same edge; the other sources are registered once.
    wire logic any_stop = |{other_ext_release, key_wake_line};
    wire logic any_sleep = any_stop | rtc_event | (|two_phase_counter_event);
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property ($rose(psel && penable)
        |-> !pready ##1 pready)
        else $error("pready missed its single wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr disagrees with the address map");
    a_rdata_idle: assert property ((!pready || pslverr)
        |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside a good transfer");
    a_lane_zero: assert property (pready && !pwrite && is_cfg
        |-> (prdata & 32'h8282_8282) == 32'h0000_0000)
        else $error("reserved lane bits read nonzero");
    a_stop_src: assert property (release_stop ==
        ((|release_req) || $past(any_stop)))
        else $error("stop release does not follow its sources");
    a_sleep_src: assert property (release_sleep ==
        ((|release_req) || $past(any_sleep)))
        else $error("sleep release does not follow its sources");
    a_idle_stop: assert property (release_idle == release_stop)
        else $error("idle release differs from stop release");
    cover property (pready && pslverr);
    cover property ($rose(release_req[0]));
    cover property (release_sleep && !release_stop);
endmodule
bind sws_top sws_monitor mon_u (.*);
`default_nettype wire

// file: test/sws_pins.sv
// Behavioural model of the wake pins and the other release sources.
`timescale 1ns/100ps
`default_nettype none
module sws_pins (
    input wire logic pclk,
    output logic [3:0] wake_pin,
    output logic [7:0] other_ext_release,
    output logic [31:0] key_wake_line,
    output logic rtc_event,
    output logic [1:0] two_phase_counter_event
);
    initial begin
        wake_pin = 4'h0;
        other_ext_release = 8'h00;
        key_wake_line = 32'h0000_0000;
        rtc_event = 1'b0;
        two_phase_counter_event = 2'h0;
    end
    // Sources move only just after an edge, so none is seen half changed.
    task automatic drive(input logic [3:0] w, input logic [7:0] o,
            input logic [31:0] k, input logic [2:0] s);
        @(posedge pclk);
        wake_pin <= w;
        other_ext_release <= o;
        key_wake_line <= k;
        rtc_event <= s[0];
        two_phase_counter_event <= s[2:1];
    endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking testbench of the standby wake-up source block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [31:0] CFG = sws_pkg::SWS_CFG_A_ADDR;
    localparam logic [31:0] STA = sws_pkg::SWS_IRQ_STAT_ADDR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, key_wake_line, rd;
    logic pready, pslverr, rtc_event, er, irq;
    logic release_stop, release_sleep, release_idle;
    logic [3:0] release_req, wake_pin;
    logic [7:0] other_ext_release;
    logic [1:0] two_phase_counter_event;
    int miscompares = 0;
    int cmp_count = 0;
    int hits = 0;
    int ln = 0;
    int cnd[4] = '{2, 2, 2, 2};
    int en[4] = '{0, 0, 0, 0};
    int st[4] = '{0, 0, 0, 0};
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) if (release_req[ln] === 1'b1) hits <= hits + 1;
    sws_top dut_u (.*);
    sws_pins pins_u (.*);
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic wrap_up();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got,
            input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a,
            input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [31:0] a,
            input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(nm, rd, e);
        chk("pslverr", er, 32'h0000_0000);
    endtask
    function automatic logic [31:0] cfg_exp();
        logic [31:0] v;
        for (int n = 0; n < 4; n++) begin
            v[8*n +: 8] = 8'(en[n] | st[n] << 2 | cnd[n] << 4);
        end
        return v;
    endfunction
    initial begin
        #125000;
        miscompares++;
        wrap_up();
    end
    initial begin
        logic [31:0] d;
        logic [3:0] s;
        int c, e, h0;
        void'($urandom(47));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("reset cfg", CFG, 32'h2020_2020);
        repeat (4) begin
            d = $urandom & 32'hbfbf_bfbf;
            s = 4'($urandom);
            apb(1'b1, CFG, d, s);
            for (int n = 0; n < 4; n++) begin
                if (s[n]) begin
                    en[n] = int'(d[8*n]);
                    cnd[n] = int'(d[8*n+4 +: 2]);
                end
            end
            rdc("cfg rw", CFG, cfg_exp());
        end
        apb(1'b1, 32'hffff_ee14, 32'hffff_ffff, 4'hf);
        chk("unmapped err", er, 32'h1);
        for (int i = 0; i < 6; i++) begin
            c = (i == 5) ? 4 : i;
            e = (i < 5) ? 1 : 0;
            d = 32'h2020_2020;
            d[8*(i%4) +: 8] = 8'(e | c << 4);
            apb(1'b1, CFG, d, 4'hf);
            ln = i % 4;
            en = '{0, 0, 0, 0};
            cnd = '{2, 2, 2, 2};
            en[ln] = e;
            cnd[ln] = c;
            rdc("cfg set", CFG, cfg_exp());
            for (int p = 1; p >= 0; p--) begin
                h0 = hits;
                pins_u.drive(4'(p << ln), 8'h00, 32'h0000_0000, 3'h0);
                repeat (8) @(posedge pclk);
                chk("level", release_req[ln], e && c == p);
                if (c > 1) chk("pulses", hits - h0, e && c != 3 - p);
                st[ln] = (e && c > 1 && c != 3 - p) ? 2 - p : 0;
                rdc("status", CFG, cfg_exp());
                st[ln] = 0;
            end
        end
        apb(1'b1, CFG, 32'h2020_2020, 4'hf);
        apb(1'b0, STA, 32'h0000_0000, 4'h0);
        apb(1'b1, CFG, 32'h1111_1111, 4'hf);
        pins_u.drive(4'hf, 8'h00, 32'h0000_0000, 3'h0);
        repeat (8) @(posedge pclk);
        chk("irq masked", irq, 32'h0);
        apb(1'b1, sws_pkg::SWS_IRQ_MASK_ADDR, 32'h0000_0001, 4'h1);
        repeat (3) @(posedge pclk);
        chk("irq set", irq, 32'h1);
        rdc("mask rd", sws_pkg::SWS_IRQ_MASK_ADDR, 32'h0000_0001);
        rdc("irq status", STA, 32'h0000_000f);
        repeat (3) @(posedge pclk);
        chk("irq clear", irq, 32'h0);
        pins_u.drive(4'h0, 8'h00, 32'h0000_0000, 3'h0);
        apb(1'b1, CFG, 32'h2020_2020, 4'hf);
        for (int i = 0; i < 4; i++) begin
            pins_u.drive(4'h0, 8'(i == 0), 32'(i == 1) << 31,
                3'(i > 1) << (2 * (i - 2)));
            repeat (4) @(posedge pclk);
            chk("stop", release_stop, i < 2);
            chk("sleep", release_sleep, 32'h1);
            rdc("live", sws_pkg::SWS_LIVE_ADDR,
                (i < 2) ? 32'h0000_0070 : 32'h0000_0020);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
